// >>> rtl/dsrb_register_bank.sv
// Three-wire serial port and control register bank of the dual converter.
`timescale 1ns/1ps
`default_nettype none
module dsrb_register_bank
  import dsrb_pkg::*;
#(
  // Arbitrary revision code.
  parameter logic [7:0] REVISION_CODE = 8'h5A
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sclkPin,
  input wire logic chipSelectNPin,
  input wire logic sdioIn,
  input wire logic portResetPin,
  output logic sdioOut,
  output logic sdioOe,
  output dsrb_power_type powerCtrl,
  output logic sampleTwosComplement,
  output logic softResetActive
);

  dsrb_pins_type pinsAsync;
  dsrb_pins_type pinsSync;
  dsrb_state_type state_q;
  dsrb_state_type state_d;
  logic sclkRise;
  logic sclkFall;
  logic bit_order_select;
  logic longAddr;
  logic softReset;

  assign pinsAsync = '{sclk: sclkPin, chipSelectN: chipSelectNPin, sdi: sdioIn, portReset: portResetPin};

  dsrb_sync2 #(
    .WIDTH($bits(dsrb_pins_type))
  ) pinSync (
    .clk(core_clk),
    .rstn(rstn),
    .asyncIn(pinsAsync),
    .syncOut(pinsSync)
  );

  // The serial clock is slow enough against core_clk that edges are found by sampling.
  assign sclkRise = pinsSync.sclk & ~state_q.sclkPrev;
  assign sclkFall = ~pinsSync.sclk & state_q.sclkPrev;
  assign bit_order_select = state_q.bank[0][DSRB_BIT_LSB_FIRST];
  assign longAddr = state_q.bank[0][DSRB_BIT_LONG_ADDR];
  assign softReset = state_q.bank[0][DSRB_BIT_SOFT_RESET];

  function automatic logic [7:0] readReg(input dsrb_state_type s, input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a < DSRB_REG_COUNT) begin
      v = s.bank[a[4:0]] & DSRB_WRITE_MASK[a[4:0]];
    end
    if (a == DSRB_OFS_POWER) begin
      v[DSRB_BIT_REG_STATE] = ~s.bank[1][DSRB_BIT_REG_DISABLE];
    end
    if (a == DSRB_OFS_REVISION) begin
      v = REVISION_CODE;
    end
    return v;
  endfunction

  always_comb begin
    logic [15:0] newShift;
    logic [15:0] instr;
    logic [7:0] dataByte;
    logic [12:0] nextAddr;
    logic [4:0] idx;
    newShift = 16'h0000;
    instr = 16'h0000;
    dataByte = 8'h00;
    nextAddr = 13'h0000;
    idx = 5'h00;
    state_d = state_q;
    state_d.sclkPrev = pinsSync.sclk;
    if (bit_order_select) begin
      newShift = {pinsSync.sdi, state_q.shift[15:1]};
    end else begin
      newShift = {state_q.shift[14:0], pinsSync.sdi};
    end
    if (pinsSync.portReset || pinsSync.chipSelectN) begin
      // A port reset or a raised select drops any partial byte unwritten.
      state_d.phase = DSRB_INSTR;
      state_d.bitCnt = 5'h00;
      state_d.sdoEn = 1'b0;
    end else if (sclkRise) begin
      state_d.shift = newShift;
      state_d.bitCnt = state_q.bitCnt + 5'h01;
      case (state_q.phase)
        DSRB_INSTR: begin
          if (state_q.bitCnt == 5'(longAddr ? DSRB_INSTR_LONG_LAST : DSRB_INSTR_SHORT_LAST)) begin
            if (longAddr) begin
              instr = newShift;
              state_d.addr = instr[12:0];
            end else begin
              instr = {bit_order_select ? newShift[15:8] : newShift[7:0], 8'h00};
              state_d.addr = {8'h00, instr[12:8]};
            end
            state_d.isRead = instr[15];
            state_d.bytesLeft = instr[14:13];
            state_d.rdByte = readReg(state_q, state_d.addr);
            state_d.phase = DSRB_DATA;
            state_d.bitCnt = 5'h00;
          end
        end
        DSRB_DATA: begin
          if (state_q.bitCnt == 5'(DSRB_DATA_LAST)) begin
            dataByte = bit_order_select ? newShift[15:8] : newShift[7:0];
            idx = state_q.addr[4:0];
            // Writes land at the last bit of each byte, not at the end of the transaction.
            if (!state_q.isRead && state_q.addr < DSRB_REG_COUNT && (!softReset || idx == 5'h00)) begin
              state_d.bank[idx] = (state_q.bank[idx] & ~DSRB_WRITE_MASK[idx])
                | (dataByte & DSRB_WRITE_MASK[idx]);
            end
            nextAddr = bit_order_select ? state_q.addr + 13'h0001 : state_q.addr - 13'h0001;
            state_d.addr = nextAddr;
            state_d.rdByte = readReg(state_d, nextAddr);
            state_d.bitCnt = 5'h00;
            state_d.bytesLeft = state_q.bytesLeft - 2'h1;
            if (state_q.bytesLeft == 2'h0 || state_d.bank[0][DSRB_BIT_SOFT_RESET]) begin
              // Setting soft reset also resets the port: the rest of the transaction is ignored.
              state_d.phase = DSRB_HALT;
            end
          end
        end
        DSRB_HALT: begin
          state_d.bitCnt = state_q.bitCnt;
        end
        default: begin
          state_d.phase = DSRB_HALT;
        end
      endcase
    end else if (sclkFall && state_q.phase == DSRB_DATA && state_q.isRead) begin
      state_d.sdoEn = 1'b1;
      state_d.sdoBit = state_q.rdByte[bit_order_select ? state_q.bitCnt[2:0] : 3'(7 - state_q.bitCnt[2:0])];
    end
    // Everything but the configuration register is pinned at default while soft reset is held.
    if (state_d.bank[0][DSRB_BIT_SOFT_RESET]) begin
      state_d.bank[20:1] = DSRB_RESET_VALUE[20:1];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '{phase: DSRB_INSTR, bank: DSRB_RESET_VALUE, default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  assign sdioOut = state_q.sdoBit;
  assign sdioOe = state_q.sdoEn;
  assign softResetActive = state_q.bank[0][DSRB_BIT_SOFT_RESET];
  assign sampleTwosComplement = state_q.bank[2][DSRB_BIT_TWOS];
  assign powerCtrl.coreRegulatorDisable = state_q.bank[1][DSRB_BIT_REG_DISABLE];
  assign powerCtrl.globalPowerDown = state_q.bank[1][DSRB_BIT_POWER_DOWN];
  assign powerCtrl.qOutputCurrentDisable = state_q.bank[1][DSRB_BIT_Q_OUT_OFF];
  assign powerCtrl.iOutputCurrentDisable = state_q.bank[1][DSRB_BIT_I_OUT_OFF];
  assign powerCtrl.qClockGate = state_q.bank[1][DSRB_BIT_Q_CLK_OFF];
  assign powerCtrl.iClockGate = state_q.bank[1][DSRB_BIT_I_CLK_OFF];
  assign powerCtrl.internalReferenceDisable = state_q.bank[1][DSRB_BIT_EXT_REF];

  // A function result cannot be bit-selected directly, so the power readback gets a net of its own.
  logic [7:0] powerReadback;
  assign powerReadback = readReg(state_q, DSRB_OFS_POWER);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // Soft reset checks.
  soft_reset_hold_a: assert property (
    softResetActive |-> state_q.bank[20:1] == DSRB_RESET_VALUE[20:1])
    else $error("Registers left default while soft reset is held.");

  soft_reset_release_a: assert property (
    softResetActive && !(sclkRise && state_q.phase == DSRB_DATA)
    |=> softResetActive)
    else $error("Soft reset dropped without a serial write.");

  // The write that sets soft reset must also stop the port for the rest of the frame.
  soft_reset_abort_a: assert property (
    $rose(softResetActive) |-> state_q.phase == DSRB_HALT)
    else $error("Soft reset did not end the transaction.");

  // Register content checks.
  regulator_state_a: assert property (
    powerReadback[DSRB_BIT_REG_STATE] == ~powerCtrl.coreRegulatorDisable)
    else $error("Regulator state bit does not mirror the regulator.");

  unmapped_zero_a: assert property (
    readReg(state_q, DSRB_OFS_UNUSED) == 8'h00
    && readReg(state_q, DSRB_OFS_CAL_STATUS) == 8'h00)
    else $error("Unmapped address reads nonzero.");

  config_reserved_a: assert property (
    (state_q.bank[0] & ~DSRB_WRITE_MASK[0]) == 8'h00)
    else $error("Reserved configuration bits were stored.");

  revision_read_a: assert property (
    readReg(state_q, DSRB_OFS_REVISION) == REVISION_CODE)
    else $error("Revision word does not read its fixed code.");

  // Only the last bit of a write data byte may change the bank.
  instr_no_write_a: assert property (
    state_q.phase == DSRB_INSTR |=> $stable(state_q.bank))
    else $error("Bank changed during the instruction phase.");

  halt_no_write_a: assert property (
    state_q.phase == DSRB_HALT |=> $stable(state_q.bank))
    else $error("Bank changed after the counted bytes.");

  read_no_write_a: assert property (
    state_q.phase == DSRB_DATA && state_q.isRead |=> $stable(state_q.bank))
    else $error("Bank changed during a read.");

  // Instruction decode checks.
  instr_length_a: assert property (
    state_q.phase == DSRB_INSTR ##1 state_q.phase == DSRB_DATA
    |-> $past(state_q.bitCnt) == 5'(longAddr ? DSRB_INSTR_LONG_LAST : DSRB_INSTR_SHORT_LAST))
    else $error("Instruction ended at the wrong bit count.");

  instr_count_bound_a: assert property (
    state_q.phase == DSRB_INSTR |-> state_q.bitCnt <= 5'(DSRB_INSTR_LONG_LAST))
    else $error("Instruction bit counter ran past its end.");

  short_addr_a: assert property (
    sclkRise && state_q.phase == DSRB_INSTR && state_q.bitCnt == 5'(DSRB_INSTR_SHORT_LAST)
    && !longAddr && !pinsSync.portReset && !pinsSync.chipSelectN
    |=> state_q.addr[12:5] == 8'h00)
    else $error("Short instruction loaded a wide address.");

  read_count_a: assert property (
    sclkRise && state_q.phase == DSRB_INSTR && !pinsSync.chipSelectN
    && !pinsSync.portReset ##1 state_q.phase == DSRB_DATA |-> state_q.bytesLeft <= 2'h3
    && state_q.rdByte == readReg(state_q, state_q.addr))
    else $error("First read byte not loaded from the start address.");

  // Data phase checks.
  data_count_bound_a: assert property (
    state_q.phase == DSRB_DATA |-> state_q.bitCnt <= 5'(DSRB_DATA_LAST))
    else $error("Data bit counter ran past its end.");

  last_byte_halt_a: assert property (
    sclkRise && state_q.phase == DSRB_DATA && state_q.bitCnt == 5'(DSRB_DATA_LAST)
    && state_q.bytesLeft == 2'h0 && !pinsSync.portReset && !pinsSync.chipSelectN
    |=> state_q.phase == DSRB_HALT)
    else $error("Port kept accepting bytes after the counted ones.");

  byte_step_a: assert property (
    sclkRise && state_q.phase == DSRB_DATA && state_q.bitCnt == 5'(DSRB_DATA_LAST)
    && state_q.bytesLeft != 2'h0 && !state_d.bank[0][DSRB_BIT_SOFT_RESET]
    && !pinsSync.portReset && !pinsSync.chipSelectN
    |=> state_q.phase == DSRB_DATA && state_q.bytesLeft == $past(state_q.bytesLeft) - 2'h1)
    else $error("Byte count did not step after a data byte.");

  addr_step_a: assert property (
    sclkRise && state_q.phase == DSRB_DATA && state_q.bitCnt == 5'h07
    && !pinsSync.portReset && !pinsSync.chipSelectN
    |=> state_q.addr == ($past(bit_order_select) ? $past(state_q.addr) + 13'h0001 : $past(state_q.addr) - 13'h0001))
    else $error("Address did not step in the bit order direction.");

  write_immediate_a: assert property (
    sclkRise && state_q.phase == DSRB_DATA && state_q.bitCnt == 5'h07
    && !state_q.isRead && state_q.addr == DSRB_OFS_FORMAT && !softReset
    && !pinsSync.portReset && !pinsSync.chipSelectN
    |=> state_q.bank[2] == (($past(bit_order_select) ? $past(state_d.shift[15:8]) : $past(state_d.shift[7:0]))
    & DSRB_WRITE_MASK[2]))
    else $error("Written byte not stored at its last bit.");

  // Bit order checks on the shifter and on the first read bit.
  msb_shift_a: assert property (
    sclkRise && !bit_order_select && !pinsSync.portReset && !pinsSync.chipSelectN
    |=> state_q.shift[0] == $past(pinsSync.sdi))
    else $error("MSB first bit not shifted in at the bottom.");

  lsb_shift_a: assert property (
    sclkRise && bit_order_select && !pinsSync.portReset && !pinsSync.chipSelectN
    |=> state_q.shift[15] == $past(pinsSync.sdi))
    else $error("LSB first bit not shifted in at the top.");

  first_read_bit_a: assert property (
    sclkFall && state_q.phase == DSRB_DATA && state_q.isRead && state_q.bitCnt == 5'h00
    && !pinsSync.chipSelectN && !pinsSync.portReset
    |=> state_q.sdoBit == $past(bit_order_select ? state_q.rdByte[0] : state_q.rdByte[7]))
    else $error("First read bit not taken from the order's end.");

  // Line and framing checks.
  drive_on_fall_a: assert property (
    $changed(state_q.sdoBit) |-> $past(sclkFall))
    else $error("Read data changed away from a falling serial clock.");

  drive_only_read_a: assert property (
    sdioOe |-> state_q.isRead)
    else $error("Serial line driven outside a read.");

  select_idle_a: assert property (
    pinsSync.chipSelectN
    |=> state_q.phase == DSRB_INSTR && state_q.bitCnt == 5'h00 && !sdioOe)
    else $error("Port not idle while chip select is high.");

  port_reset_a: assert property (
    pinsSync.portReset |=> state_q.phase == DSRB_INSTR
    && state_q.bitCnt == 5'h00 && !sdioOe)
    else $error("Port reset did not return the port to the instruction phase.");

  // Global power down must leave the serial port counting so the registers stay reachable.
  power_down_port_a: assert property (
    powerCtrl.globalPowerDown && sclkRise && state_q.phase == DSRB_INSTR
    && !pinsSync.chipSelectN && !pinsSync.portReset
    |=> state_q.bitCnt != $past(state_q.bitCnt))
    else $error("Serial port stopped while powered down.");

endmodule
`default_nettype wire

// >>> rtl/dsrb_pkg.sv
// Package with register map, field positions, reset values and types of the serial register bank.
package dsrb_pkg;

  localparam logic [12:0] DSRB_OFS_SERIAL_CFG = 13'h0000;
  localparam logic [12:0] DSRB_OFS_POWER = 13'h0001;
  localparam logic [12:0] DSRB_OFS_FORMAT = 13'h0002;
  localparam logic [12:0] DSRB_OFS_I_FINE_GAIN = 13'h0003;
  localparam logic [12:0] DSRB_OFS_I_FS_RES = 13'h0004;
  localparam logic [12:0] DSRB_OFS_I_CM_RES = 13'h0005;
  localparam logic [12:0] DSRB_OFS_Q_FINE_GAIN = 13'h0006;
  localparam logic [12:0] DSRB_OFS_Q_FS_RES = 13'h0007;
  localparam logic [12:0] DSRB_OFS_Q_CM_RES = 13'h0008;
  localparam logic [12:0] DSRB_OFS_Q_AUX_LOW = 13'h0009;
  localparam logic [12:0] DSRB_OFS_Q_AUX_CTRL = 13'h000A;
  localparam logic [12:0] DSRB_OFS_I_AUX_LOW = 13'h000B;
  localparam logic [12:0] DSRB_OFS_I_AUX_CTRL = 13'h000C;
  localparam logic [12:0] DSRB_OFS_REF_TRIM = 13'h000D;
  localparam logic [12:0] DSRB_OFS_CAL_CTRL = 13'h000E;
  localparam logic [12:0] DSRB_OFS_CAL_STATUS = 13'h000F;
  localparam logic [12:0] DSRB_OFS_CAL_POINTER = 13'h0010;
  localparam logic [12:0] DSRB_OFS_CAL_WORD = 13'h0011;
  localparam logic [12:0] DSRB_OFS_CAL_ACCESS = 13'h0012;
  localparam logic [12:0] DSRB_OFS_UNUSED = 13'h0013;
  localparam logic [12:0] DSRB_OFS_CLOCK_MODE = 13'h0014;
  localparam logic [12:0] DSRB_OFS_REVISION = 13'h001F;
  // First address past the stored registers; the revision word is not stored.
  localparam logic [12:0] DSRB_REG_COUNT = 13'h0015;

  // Serial configuration fields.
  localparam int DSRB_BIT_LSB_FIRST = 6;
  localparam int DSRB_BIT_SOFT_RESET = 5;
  localparam int DSRB_BIT_LONG_ADDR = 4;
  // Power control fields.
  localparam int DSRB_BIT_REG_DISABLE = 7;
  localparam int DSRB_BIT_REG_STATE = 6;
  localparam int DSRB_BIT_POWER_DOWN = 5;
  localparam int DSRB_BIT_Q_OUT_OFF = 4;
  localparam int DSRB_BIT_I_OUT_OFF = 3;
  localparam int DSRB_BIT_Q_CLK_OFF = 2;
  localparam int DSRB_BIT_I_CLK_OFF = 1;
  localparam int DSRB_BIT_EXT_REF = 0;
  // Format control field.
  localparam int DSRB_BIT_TWOS = 7;
  // Instruction and data fields.
  localparam int DSRB_INSTR_SHORT_LAST = 7;
  localparam int DSRB_INSTR_LONG_LAST = 15;
  localparam int DSRB_DATA_LAST = 7;

  // Writable bits per stored register, index 20 first; status and reserved bits are zero.
  localparam logic [20:0][7:0] DSRB_WRITE_MASK = {
    8'hCF, 8'h00, 8'hDF, 8'h3F, 8'h3F, 8'h00, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hBF, 8'hBF, 8'h3F, 8'hBF, 8'hBF, 8'h3F, 8'hBF, 8'hBF, 8'h70};
  localparam logic [20:0][7:0] DSRB_RESET_VALUE = {
    8'h00, 8'h00, 8'h00, 8'h34, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h34, 8'h40, 8'h00};

  typedef enum logic [1:0] {DSRB_INSTR, DSRB_DATA, DSRB_HALT} dsrb_phase_type;

  typedef struct packed {
    logic coreRegulatorDisable;
    logic globalPowerDown;
    logic qOutputCurrentDisable;
    logic iOutputCurrentDisable;
    logic qClockGate;
    logic iClockGate;
    logic internalReferenceDisable;
  } dsrb_power_type;

  typedef struct packed {
    logic sclk;
    logic chipSelectN;
    logic sdi;
    logic portReset;
  } dsrb_pins_type;

  typedef struct packed {
    dsrb_phase_type phase;
    logic sclkPrev;
    logic [15:0] shift;
    logic [4:0] bitCnt;
    logic isRead;
    logic [1:0] bytesLeft;
    logic [12:0] addr;
    logic [7:0] rdByte;
    logic sdoBit;
    logic sdoEn;
    logic [20:0][7:0] bank;
  } dsrb_state_type;

endpackage

// >>> rtl/dsrb_sync2.sv
// Two flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module dsrb_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1_q <= '0;
      syncOut <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/dsrb_spi_host.sv
// Serial host controller model that frames transfers on the three-wire port.
`timescale 1ns/1ps
`default_nettype none
module dsrb_spi_host (
  input wire logic core_clk,
  input wire logic sdioWire,
  output logic sclk,
  output logic chipSelectN,
  output logic hostData,
  output logic portReset
);
  // Half serial period in core cycles; four gives the 200 ns link period, more gives a slow host.
  int halfCycles = 4;
  initial begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    hostData = 1'b0;
    portReset = 1'b0;
  end
  task automatic step();
    repeat (halfCycles) @(posedge core_clk);
    #1;
  endtask
  task automatic open_frame();
    @(posedge core_clk);
    #1;
    chipSelectN = 1'b0;
    step();
  endtask
  // Data moves only while the serial clock is low, so it is stable across every rising edge.
  // A released line toggles so that a stale value can never pass for read data.
  task automatic shift(input logic [15:0] val, input int n, input logic lsb, input logic drv,
                       output logic [15:0] got);
    int idx;
    got = 16'h0000;
    for (int i = 0; i < n; i++) begin
      idx = lsb ? i : n - 1 - i;
      hostData = drv ? val[idx] : ~hostData;
      step();
      got[idx] = sdioWire;
      sclk = 1'b1;
      step();
      sclk = 1'b0;
    end
  endtask
  task automatic close_frame();
    step();
    chipSelectN = 1'b1;
    hostData = ~hostData;
    step();
    step();
  endtask
  task automatic pulse_reset();
    portReset = 1'b1;
    step();
    portReset = 1'b0;
    step();
  endtask
endmodule
`default_nettype wire

// >>> testbench/dsrb_register_bank_tb_top.sv
// Self-checking bench for the serial register bank, driven through the host controller model.
`timescale 1ns/1ps
`default_nettype none
module dsrb_register_bank_tb_top
  import dsrb_pkg::*;
();
  // Arbitrary revision code.
  localparam logic [7:0] REV = 8'hC7;
  logic core_clk, rstn, sclk, csN, hostData, portRst, sdioOut, sdioOe, sdioWire, twos, softRst;
  dsrb_power_type power;
  int miscompares = 0;
  int checkCount = 0;
  logic lsbMode = 1'b0;
  logic longMode = 1'b0;
  logic [3:0][7:0] x;
  logic [15:0] got;
  assign sdioWire = sdioOe ? sdioOut : hostData;
  dsrb_register_bank #(.REVISION_CODE(REV)) i_dut (.core_clk(core_clk), .rstn(rstn), .sclkPin(sclk),
    .chipSelectNPin(csN), .sdioIn(sdioWire), .portResetPin(portRst), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .powerCtrl(power), .sampleTwosComplement(twos), .softResetActive(softRst));
  dsrb_spi_host i_host (.core_clk(core_clk), .sdioWire(sdioWire), .sclk(sclk), .chipSelectN(csN),
    .hostData(hostData), .portReset(portRst));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
    checkCount++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic access(input logic rd, input logic [12:0] a, input int n, input logic [3:0][7:0] wd,
                        output logic [3:0][7:0] rdat);
    logic [15:0] ins;
    logic [15:0] g;
    rdat = '0;
    ins = longMode ? {rd, 2'(n - 1), a} : {8'h00, rd, 2'(n - 1), a[4:0]};
    i_host.open_frame();
    i_host.shift(ins, longMode ? 16 : 8, lsbMode, 1'b1, g);
    for (int k = 0; k < n; k++) begin
      i_host.shift({8'h00, wd[k]}, 8, lsbMode, !rd, g);
      rdat[k] = g[7:0];
    end
    i_host.close_frame();
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [3:0][7:0] y;
    access(1'b0, a, 1, {24'h0, d}, y);
  endtask
  task automatic rd_check(input logic [12:0] a, input logic [7:0] e, input string what);
    logic [3:0][7:0] y;
    access(1'b1, a, 1, '0, y);
    check(y[0], e, what);
  endtask
  task automatic s_reset();
    for (int a = 0; a <= 20; a++) begin
      rd_check(13'(a), a == 1 ? 8'h40 : (a == 2 || a == 17) ? 8'h34 : 8'h00, "reset value");
    end
    rd_check(DSRB_OFS_REVISION, REV, "revision");
    check({1'b0, power}, 8'h00, "power pins");
    check({6'h00, twos, sdioOe}, 8'h00, "format pin and idle line");
  endtask
  task automatic s_masks();
    logic [7:0] v;
    for (int a = 1; a <= 20; a++) begin
      wr(13'(a), 8'hFF);
      rd_check(13'(a), DSRB_WRITE_MASK[a], "write mask");
    end
    wr(DSRB_OFS_REVISION, 8'hFF);
    rd_check(DSRB_OFS_REVISION, REV, "read only");
    check({7'h00, twos}, 8'h01, "twos format");
    for (int b = 0; b < 8; b++) begin
      v = 8'h01 << b;
      wr(DSRB_OFS_POWER, v);
      check({1'b0, power}, {1'b0, v[7], v[5:0]}, "power bit");
      rd_check(DSRB_OFS_POWER, (v & 8'hBF) | (v[7] ? 8'h00 : 8'h40), "power read");
    end
    wr(DSRB_OFS_POWER, 8'h00);
    wr(DSRB_OFS_FORMAT, 8'h00);
    check({7'h00, twos}, 8'h00, "unsigned format");
  endtask
  task automatic s_multi();
    i_host.open_frame();
    i_host.shift(16'h0022, 8, 1'b0, 1'b1, got);
    i_host.shift(16'h0080, 8, 1'b0, 1'b1, got);
    check({7'h00, twos}, 8'h01, "early update");
    i_host.shift(16'h0028, 8, 1'b0, 1'b1, got);
    check({1'b0, power}, 8'h28, "next byte down");
    i_host.shift(16'h00FF, 8, 1'b0, 1'b1, got);
    i_host.close_frame();
    access(1'b1, 13'h0002, 3, '0, x);
    check(x[0], 8'h80, "burst byte 0");
    check(x[1], 8'h68, "burst byte 1");
    check(x[2], 8'h00, "extra byte ignored");
  endtask
  task automatic s_lsb();
    wr(DSRB_OFS_SERIAL_CFG, 8'h40);
    lsbMode = 1'b1;
    i_host.halfCycles = 6;
    access(1'b0, 13'h0009, 2, {16'h0, 8'h71, 8'h0D}, x);
    access(1'b1, 13'h0009, 2, '0, x);
    check(x[0], 8'h0D, "lsb byte 0");
    check(x[1], 8'h71, "lsb byte 1");
    rd_check(DSRB_OFS_SERIAL_CFG, 8'h40, "order bit");
    wr(DSRB_OFS_SERIAL_CFG, 8'h00);
    lsbMode = 1'b0;
    i_host.halfCycles = 4;
    rd_check(13'h0009, 8'h0D, "msb again");
  endtask
  task automatic s_long();
    wr(DSRB_OFS_SERIAL_CFG, 8'h10);
    longMode = 1'b1;
    wr(13'h0003, 8'h15);
    rd_check(13'h0003, 8'h15, "long address");
    wr(DSRB_OFS_UNUSED, 8'hFF);
    rd_check(DSRB_OFS_UNUSED, 8'h00, "unmapped");
    wr(DSRB_OFS_SERIAL_CFG, 8'h00);
    longMode = 1'b0;
    rd_check(13'h0003, 8'h15, "short address");
  endtask
  task automatic s_soft();
    wr(DSRB_OFS_SERIAL_CFG, 8'h20);
    check({7'h00, softRst}, 8'h01, "soft reset on");
    rd_check(13'h0003, 8'h00, "defaults back");
    rd_check(DSRB_OFS_FORMAT, 8'h34, "defaults back");
    wr(13'h0003, 8'h11);
    rd_check(13'h0003, 8'h00, "held at default");
    rd_check(DSRB_OFS_SERIAL_CFG, 8'h20, "config kept");
    wr(DSRB_OFS_SERIAL_CFG, 8'h00);
    check({7'h00, softRst}, 8'h00, "soft reset off");
  endtask
  task automatic s_port();
    i_host.open_frame();
    i_host.shift(16'h0003, 8, 1'b0, 1'b1, got);
    i_host.shift(16'h000F, 4, 1'b0, 1'b1, got);
    i_host.pulse_reset();
    i_host.shift(16'h0006, 8, 1'b0, 1'b1, got);
    i_host.shift(16'h002A, 8, 1'b0, 1'b1, got);
    i_host.close_frame();
    rd_check(13'h0003, 8'h00, "aborted byte");
    rd_check(13'h0006, 8'h2A, "new instruction");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge core_clk);
    s_reset();
    s_masks();
    s_multi();
    s_lsb();
    s_long();
    s_soft();
    s_port();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
